/* File: hdl/pin_mux_pkg.sv */
/*
 * Shared constants and carrier types for the programmable pin mux.
 * Assumes a single processor clock domain and an asynchronous active-high reset.
 */
package pin_mux_pkg;

   localparam int NUM_PINS = 32;

   // Register offsets on the plain register port
   localparam logic [3:0] OFS_ENABLE    = 4'h0;
   localparam logic [3:0] OFS_DIR       = 4'h1;
   localparam logic [3:0] OFS_DATA      = 4'h2;
   localparam logic [3:0] OFS_PULLDN    = 4'h3;
   localparam logic [3:0] OFS_PIN_IN    = 4'h4;
   localparam logic [3:0] OFS_AUX_CTRL  = 4'h5;
   localparam logic [3:0] OFS_STRAP_ST  = 4'h6;

   // Power-on defaults: 1 = programmable function enabled
   localparam logic [31:0] RST_ENABLE   = 32'hFFFF_FC0F;
   // 1 = output; every default pin is an input
   localparam logic [31:0] RST_DIR      = 32'h0000_0000;
   localparam logic [31:0] RST_DATA     = 32'h0000_0000;
   // 1 = pulldown, 0 = pullup (pins 1, 6, 10, 22, 23)
   localparam logic [31:0] RST_PULLDN   = 32'h00C0_0442;
   // Pins that revert to normal function when the address strap is low
   localparam logic [31:0] STRAP_REVERT = 32'h2400_0380;

   // Auxiliary control field positions
   localparam int AUX_ADDR_PIN_SEL = 0;
   localparam int AUX_ADDR_FLOAT   = 1;
   localparam logic [1:0] RST_AUX  = 2'h1;

   // Peripheral region geometry
   localparam int REGION_BITS    = 8;
   localparam logic [2:0] SEVENTH_REGION = 3'h6;
   localparam logic [7:0] RST_PERIPH_BASE = 8'h00;

   // Strap sample window in crystal clocks after reset release
   localparam int STRAP_SAMPLE_CLKS = 3;

   typedef enum logic [1:0] {
      STRAP_WAIT   = 2'b00,
      STRAP_SAMPLE = 2'b01,
      STRAP_DONE   = 2'b11
   } strap_state_t;

   // Per-pin configuration carried as one bundle
   typedef struct packed {
      logic [NUM_PINS-1:0] enable;
      logic [NUM_PINS-1:0] dir;
      logic [NUM_PINS-1:0] data;
      logic [NUM_PINS-1:0] pulldn;
   } pin_cfg_t;

   // Bus cycle info from the core
   typedef struct packed {
      logic [19:0] addr;
      logic        addr_phase;
      logic        io_space;
      logic        cycle_valid;
   } bus_cycle_t;

endpackage

/* File: hdl/pin_sync.sv */
/*
 * Two-flip-flop synchroniser for a vector of pin inputs.
 * Assumes inputs are asynchronous to clk_i.
 */
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;

   initial begin
      if (WIDTH < 1) $error("pin_sync width must be positive");
   end

   // First stage read only by second stage
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule

/* File: hdl/strap_sampler.sv */
/*
 * Captures the address-enable strap a fixed number of clocks after reset release.
 * Assumes the strap input is already synchronised.
 */
`timescale 1ns/10ps
module strap_sampler
   import pin_mux_pkg::*;
#(
   parameter int DELAY = STRAP_SAMPLE_CLKS
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // Strap
   input  wire logic strap_i,
   output logic      strap_o,
   output logic      done_o
);
   strap_state_t state_r;
   logic [2:0]   cnt_r;

   initial begin
      if (DELAY < 1 || DELAY > 7) $error("strap delay out of range");
   end

   // Wait, sample the strap input, hold until next reset
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= STRAP_WAIT;
         cnt_r   <= 3'h0;
         strap_o <= 1'b1;
         done_o  <= 1'b0;
      end else begin
         unique case (state_r)
            STRAP_WAIT: begin
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == 3'(DELAY - 1)) state_r <= STRAP_SAMPLE;
            end
            STRAP_SAMPLE: begin
               strap_o <= strap_i;
               done_o  <= 1'b1;
               state_r <= STRAP_DONE;
            end
            STRAP_DONE: begin
               state_r <= STRAP_DONE;
            end
            default: state_r <= STRAP_WAIT;
         endcase
      end
   end
endmodule

/* File: hdl/pin_mux.sv */
/*
 * Programmable pin mux: 32 shared pins, reset defaults, address strap,
 * seventh peripheral select and latched address bit two.
 * Assumes one processor clock, bus cycle info from the core, and
 * pad drivers that resolve pin level from output enable and pulls.
 */
`timescale 1ns/10ps

// Behaviour
// - Each of 32 pins has its own enable, direction and pull selection.
// - Pins 1, 10, 22, 23 reset to pulldown inputs, the other programmable pins to pullup inputs.
// - Data direction, data bus enable and sync ready pins reset to normal function.
// - Upper address lines reset to address function for the boot fetch.
// - The seventh select goes low for accesses in the seventh 256-byte peripheral region.
// - The seventh select is held high during bus hold and reset.
// - Peripheral selects follow the multiplexed bus address phase timing.
// - With the address pin select bit at zero the pin shows latched address bit two.
// - Latched address bit two keeps its value during bus hold.
// - With the strap high, the address float bit leaves the multiplexed bus undriven in lower/upper cycle address phase.
// - With the strap low, the multiplexed bus carries address and data and status pins are normal.
// - The strap is sampled on the fourth clock after reset release and floats in hold or test mode.
// - Strap-dependent pins revert to normal function when the strap was low.
// - Normal-default pins offer pullup when programmable, sync ready a pulldown.
module pin_mux
   import pin_mux_pkg::*;
#(
   parameter int PINS = NUM_PINS
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                sys_rst_i,
   // Register port
   input  wire logic [3:0]          reg_addr_i,
   input  wire logic [31:0]         reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic      [31:0]         reg_rdata_o,
   // Core side
   input  wire pin_mux_pkg::bus_cycle_t bus_i,
   input  wire logic                bus_hold_i,
   input  wire logic                test_hiz_i,
   input  wire logic                lower_upper_cycle_i,
   input  wire logic [PINS-1:0]     normal_out_i,
   input  wire logic [PINS-1:0]     normal_oe_i,
   output logic      [PINS-1:0]     pin_sync_o,
   // Pins
   input  wire logic [PINS-1:0]     pin_i,
   output logic      [PINS-1:0]     pin_o,
   output logic      [PINS-1:0]     pin_oe_o,
   output logic      [PINS-1:0]     pin_pullup_o,
   output logic      [PINS-1:0]     pin_pulldn_o,
   input  wire logic                bus_address_strap_i,
   output logic                     strap_pin_oe_o,
   output logic                     mux_bus_addr_oe_o,
   output logic                     status_pins_normal_o,
   output logic                     periph_select_7th_n_o,
   output logic                     latched_addr_bit_two_o
);
   import pin_mux_pkg::*;

   pin_cfg_t          cfg_r;
   logic [1:0]        aux_r;
   logic [7:0]        periph_base_r;
   logic [PINS-1:0]   pin_in_s;
   logic [1:0]        strap_meta_r;
   logic              strap_sync;
   logic              strap_val;
   logic              strap_done;
   logic              strap_applied_r;
   logic              sel7_n_r;
   logic              addr2_r;
   logic              in_region7;
   logic [31:0]       rdata_nxt;

   initial begin
      if (PINS != NUM_PINS) $error("pin_mux supports exactly 32 pins");
   end

   // Pin input synchroniser
   pin_sync #(
      .WIDTH  (PINS)
   ) u_pin_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (pin_i),
      .sync_o    (pin_in_s)
   );

   // Strap synchroniser, first stage feeds only the second
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         strap_meta_r <= 2'h3;
      end else begin
         strap_meta_r <= {strap_meta_r[0], bus_address_strap_i};
      end
   end
   assign strap_sync = strap_meta_r[1];

   // Strap sampled shortly after reset release
   strap_sampler #(
      .DELAY  (STRAP_SAMPLE_CLKS)
   ) u_strap (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .strap_i   (strap_sync),
      .strap_o   (strap_val),
      .done_o    (strap_done)
   );

   // Pin configuration registers with power-on defaults
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg_r.enable    <= RST_ENABLE;
         cfg_r.dir       <= RST_DIR;
         cfg_r.data      <= RST_DATA;
         cfg_r.pulldn    <= RST_PULLDN;
         strap_applied_r <= 1'b0;
      end else begin
         if (strap_done && !strap_applied_r) begin
            strap_applied_r <= 1'b1;
            // Strap low: dependent pins revert to normal
            if (!strap_val) cfg_r.enable <= cfg_r.enable & ~STRAP_REVERT;
         end
         if (reg_wr_i) begin
            unique case (reg_addr_i)
               OFS_ENABLE: cfg_r.enable <= reg_wdata_i;
               OFS_DIR:    cfg_r.dir    <= reg_wdata_i;
               OFS_DATA:   cfg_r.data   <= reg_wdata_i;
               OFS_PULLDN: cfg_r.pulldn <= reg_wdata_i;
               default:    ;
            endcase
         end
      end
   end

   // Auxiliary control and peripheral base
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aux_r         <= RST_AUX;
         periph_base_r <= RST_PERIPH_BASE;
      end else if (reg_wr_i && reg_addr_i == OFS_AUX_CTRL) begin
         aux_r         <= reg_wdata_i[1:0];
         periph_base_r <= reg_wdata_i[15:8];
      end
   end

   // Pin drive: programmable setting overrides normal function
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (test_hiz_i) begin
            pin_o[i]    = 1'b0;
            pin_oe_o[i] = 1'b0;
         end else if (cfg_r.enable[i]) begin
            pin_o[i]    = cfg_r.data[i];
            pin_oe_o[i] = cfg_r.dir[i];
         end else begin
            pin_o[i]    = normal_out_i[i];
            pin_oe_o[i] = normal_oe_i[i];
         end
         // Weak pull only on a programmable input
         pin_pullup_o[i] = cfg_r.enable[i] && !cfg_r.dir[i] && !cfg_r.pulldn[i];
         pin_pulldn_o[i] = cfg_r.enable[i] && !cfg_r.dir[i] && cfg_r.pulldn[i];
      end
   end

   assign pin_sync_o = pin_in_s;

   // Seventh region decode: 256-byte regions above the base
   assign in_region7 = bus_i.cycle_valid && bus_i.addr_phase &&
                       (bus_i.addr[19:REGION_BITS+3] == {4'h0, periph_base_r[7:3]}) &&
                       (bus_i.addr[REGION_BITS+2:REGION_BITS] == SEVENTH_REGION);

   // Select follows the mux bus address phase, high in hold and reset
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sel7_n_r <= 1'b1;
      end else if (bus_hold_i) begin
         sel7_n_r <= 1'b1;
      end else if (bus_i.addr_phase) begin
         sel7_n_r <= !in_region7;
      end else if (!bus_i.cycle_valid) begin
         sel7_n_r <= 1'b1;
      end
   end

   // Latched address bit two, held through bus hold
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr2_r <= 1'b0;
      end else if (!bus_hold_i && bus_i.addr_phase && bus_i.cycle_valid) begin
         addr2_r <= bus_i.addr[2];
      end
   end

   // Shared pin output choice
   assign periph_select_7th_n_o  = aux_r[AUX_ADDR_PIN_SEL] ? sel7_n_r : 1'b1;
   assign latched_addr_bit_two_o = aux_r[AUX_ADDR_PIN_SEL] ? 1'b0 : addr2_r;

   // Address phase drive of mux bus
   assign mux_bus_addr_oe_o = !bus_hold_i && !test_hiz_i &&
                              !(strap_val && lower_upper_cycle_i && aux_r[AUX_ADDR_FLOAT]);
   assign status_pins_normal_o = strap_done && !strap_val;

   // Strap pin floats in hold and test mode
   assign strap_pin_oe_o = strap_done && !bus_hold_i && !test_hiz_i;

   // Register read mux
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (reg_addr_i)
         OFS_ENABLE:   rdata_nxt = cfg_r.enable;
         OFS_DIR:      rdata_nxt = cfg_r.dir;
         OFS_DATA:     rdata_nxt = cfg_r.data;
         OFS_PULLDN:   rdata_nxt = cfg_r.pulldn;
         OFS_PIN_IN:   rdata_nxt = pin_in_s;
         OFS_AUX_CTRL: rdata_nxt = {16'h0000, periph_base_r, 6'h00, aux_r};
         OFS_STRAP_ST: rdata_nxt = {30'h0000_0000, strap_done, strap_val};
         default:      rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Read data one cycle after the strobe
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_nxt;
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end
endmodule

/* File: sim/pin_mux_assertions.sv */
/*
 * Port checker for the pin mux: reset defaults, seventh select, bit two.
 * Assumes binding into pin_mux with one clock and async reset.
 */
`timescale 1ns/10ps
module pin_mux_checker
   import pin_mux_pkg::*;
(
   // Clock, reset and register port
   input  wire logic                    clk_i,
   input  wire logic                    sys_rst_i,
   input  wire logic [3:0]              reg_addr_i,
   input  wire logic [31:0]             reg_wdata_i,
   input  wire logic                    reg_wr_i,
   // Core side and pins
   input  wire pin_mux_pkg::bus_cycle_t bus_i,
   input  wire logic                    bus_hold_i,
   input  wire logic                    test_hiz_i,
   input  wire logic [31:0]             normal_oe_i,
   input  wire logic [31:0]             pin_oe_o,
   input  wire logic [31:0]             pin_pullup_o,
   input  wire logic [31:0]             pin_pulldn_o,
   input  wire logic                    strap_pin_oe_o,
   input  wire logic                    periph_select_7th_n_o,
   input  wire logic                    latched_addr_bit_two_o
);
   logic [15:0] aux_r;
   logic        rmatch;
   logic        ph;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Mirror of the auxiliary word, base and mode
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         aux_r <= {RST_PERIPH_BASE, 6'h00, RST_AUX};
      else if (reg_wr_i && reg_addr_i == OFS_AUX_CTRL)
         aux_r <= reg_wdata_i[15:0];
   end

   // Region decode and address phase outside hold
   assign rmatch = bus_i.addr[10:8] == SEVENTH_REGION && bus_i.addr[19:11] == {4'h0, aux_r[15:11]};
   assign ph     = bus_i.addr_phase && bus_i.cycle_valid && !bus_hold_i;

   a_sel_reset_high: assert property (disable iff (1'b0) sys_rst_i |-> periph_select_7th_n_o)
      else $error("select low in reset");
   a_sel_hold_high: assert property (bus_hold_i && $past(bus_hold_i) |-> periph_select_7th_n_o)
      else $error("select low in hold");
   a_sel_decode_hit: assert property (ph && rmatch && aux_r[0] |=> bus_hold_i || !periph_select_7th_n_o)
      else $error("select missed region");
   a_sel_decode_miss: assert property (ph && !rmatch |=> periph_select_7th_n_o)
      else $error("select outside region");
   a_bit_two_mode: assert property (!aux_r[0] && !$past(aux_r[0]) |-> periph_select_7th_n_o)
      else $error("select in bit two mode");
   a_bit_two_latch: assert property (ph && !aux_r[0] |=> latched_addr_bit_two_o == $past(bus_i.addr[2]))
      else $error("bit two not latched");
   a_bit_two_keep: assert property (bus_hold_i && $past(bus_hold_i) |-> $stable(latched_addr_bit_two_o))
      else $error("bit two moved in hold");
   a_strap_float: assert property (bus_hold_i || test_hiz_i |-> !strap_pin_oe_o)
      else $error("strap pin driven");
   a_reset_pulls: assert property (disable iff (1'b0) sys_rst_i |-> ((pin_pulldn_o ^ RST_PULLDN) & RST_ENABLE) == 32'h0
      && ((pin_pullup_o ^ ~RST_PULLDN) & RST_ENABLE) == 32'h0 && (pin_oe_o & RST_ENABLE) == 32'h0)
      else $error("reset pull defaults wrong");
   a_reset_normal: assert property (disable iff (1'b0) sys_rst_i |-> ((pin_oe_o ^ normal_oe_i) & ~RST_ENABLE) == 32'h0)
      else $error("bus pins not normal in reset");
endmodule

bind pin_mux pin_mux_checker u_chk (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .bus_i, .bus_hold_i,
   .test_hiz_i, .normal_oe_i, .pin_oe_o, .pin_pullup_o, .pin_pulldn_o, .strap_pin_oe_o, .periph_select_7th_n_o,
   .latched_addr_bit_two_o);

/* File: sim/pin_pads_model.sv */
/*
 * Board side of the shared pins: pads, weak pulls, outside sources, strap.
 * Assumes the mux gives per-pin drive, enable and pull selections.
 */
`timescale 1ns/10ps
module pin_pads_model (
   // Clock
   input  wire logic        clk_i,
   // Mux drive
   input  wire logic [31:0] drv_i,
   input  wire logic [31:0] oe_i,
   input  wire logic [31:0] pu_i,
   input  wire logic [31:0] pd_i,
   // Outside sources
   input  wire logic [31:0] ext_en_i,
   input  wire logic [31:0] ext_val_i,
   input  wire logic        strap_low_i,
   // Pad levels
   output logic      [31:0] lvl_o,
   output logic             strap_o
);
   logic wobble_r = 1'b0;

   // Undriven unpulled pads wander each cycle
   always_ff @(posedge clk_i) begin
      wobble_r <= ~wobble_r;
   end

   // Pad level: own drive, outside source, pull, else wander
   always_comb begin
      for (int k = 0; k < 32; k++) begin
         if (oe_i[k])
            lvl_o[k] = drv_i[k];
         else if (ext_en_i[k])
            lvl_o[k] = ext_val_i[k];
         else if (pu_i[k])
            lvl_o[k] = 1'b1;
         else if (pd_i[k])
            lvl_o[k] = 1'b0;
         else
            lvl_o[k] = wobble_r;
      end
   end

   // Strap has a weak pullup unless held low on purpose
   assign strap_o = ~strap_low_i;
endmodule

/* File: sim/test_pin_mux.sv */
/*
 * Testbench for the pin mux: reset defaults, strap, pins, select, bit two.
 * Assumes the register port protocol and pad model beside it.
 */
`timescale 1ns/10ps
module test_pin_mux;
   import pin_mux_pkg::*;
   logic                  clk_i = 1'b0;
   logic                  sys_rst_i = 1'b0;
   logic [3:0]            reg_addr_i = 4'h0;
   logic [31:0]           reg_wdata_i = 32'h0;
   logic                  reg_wr_i = 1'b0;
   logic                  reg_rd_i = 1'b0;
   logic                  bus_hold_i = 1'b0;
   logic                  test_hiz_i = 1'b0;
   logic                  lower_upper_cycle_i = 1'b0;
   logic                  strap_low = 1'b0;
   bus_cycle_t            bus_i = '0;
   logic [31:0]           normal_out_i = 32'h5A5A_C3C3;
   logic [31:0]           normal_oe_i = 32'hFFFF_0000;
   logic [31:0]           ext_en = 32'h0;
   logic [31:0]           rd_v;
   wire logic [31:0]      reg_rdata_o, lvl, pin_o, pin_oe_o, pin_pullup_o, pin_pulldn_o, pin_sync_o;
   wire logic             mux_bus_addr_oe_o;
   wire logic             strap, strap_pin_oe_o, status_pins_normal_o, periph_select_7th_n_o, latched_addr_bit_two_o;
   int                    n_fail = 0;
   int                    n_tests = 0;
   int                    cyc = 0;

   pin_mux dut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_i,
      .bus_hold_i, .test_hiz_i, .lower_upper_cycle_i, .normal_out_i, .normal_oe_i, .pin_sync_o,
      .pin_i(lvl), .pin_o, .pin_oe_o, .pin_pullup_o, .pin_pulldn_o, .bus_address_strap_i(strap), .strap_pin_oe_o,
      .mux_bus_addr_oe_o, .status_pins_normal_o, .periph_select_7th_n_o, .latched_addr_bit_two_o);
   pin_pads_model pads (.clk_i, .drv_i(pin_o), .oe_i(pin_oe_o), .pu_i(pin_pullup_o), .pd_i(pin_pulldn_o),
      .ext_en_i(ext_en), .ext_val_i(32'h0), .strap_low_i(strap_low), .lvl_o(lvl), .strap_o(strap));

   // Clock and hang guard
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // Compare, register and bus cycle tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      // Read data stands in the cycle after the strobe; taken at its closing edge
      @(posedge clk_i);
      rd_v = reg_rdata_o;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_v, exp);
   endtask
   task automatic bcyc(input logic [19:0] a, input logic s, input logic b);
      bus_i <= {a, 3'b111};
      @(posedge clk_i);
      bus_i.addr_phase <= 1'b0;
      #1 chk({periph_select_7th_n_o, latched_addr_bit_two_o}, {s, b});
      @(posedge clk_i);
   endtask
   task automatic rst(input logic low);
      int i;
      ext_en <= 32'h0;
      strap_low <= low;
      sys_rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd_v = 32'h0;
      for (i = 0; i < 20 && rd_v[1] !== 1'b1; i++)
         rd(OFS_STRAP_ST);
      chk(rd_v, {30'h0, 1'b1, ~low});
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      rst(1'b0);
      rdc(OFS_ENABLE, RST_ENABLE);
      rdc(OFS_DIR, RST_DIR);
      rdc(OFS_PULLDN, RST_PULLDN);
      rdc(OFS_AUX_CTRL, {16'h0, RST_PERIPH_BASE, 6'h00, RST_AUX});
      rdc(4'hF, 32'h0);
      chk(status_pins_normal_o, 32'h0);
      wr(OFS_ENABLE, 32'hFFFF_FFFF);
      wr(OFS_DIR, 32'h4);
      wr(OFS_DATA, 32'h0);
      ext_en <= 32'h2000_0000;
      repeat (3) @(posedge clk_i);
      chk(pin_oe_o, 32'h4);
      chk(pin_sync_o & 32'hDFFF_FFFB, ~RST_PULLDN & 32'hDFFF_FFFB);
      rdc(OFS_PIN_IN, ~RST_PULLDN & 32'hDFFF_FFFB);
      wr(OFS_PULLDN, ~RST_PULLDN);
      wr(OFS_DATA, 32'h4);
      repeat (3) @(posedge clk_i);
      rdc(OFS_PIN_IN, (RST_PULLDN & 32'hDFFF_FFFB) | 32'h4);
      wr(OFS_ENABLE, 32'h0);
      chk(pin_o & 32'h3F0, normal_out_i & 32'h3F0);
      chk(pin_oe_o & 32'h3F0, normal_oe_i & 32'h3F0);
      // Strap high: float bit releases the mux bus in lower/upper address phase
      lower_upper_cycle_i <= 1'b1;
      wr(OFS_AUX_CTRL, 32'h0003);
      chk(mux_bus_addr_oe_o, 32'h0);
      lower_upper_cycle_i <= 1'b0;
      @(posedge clk_i);
      chk(mux_bus_addr_oe_o, 32'h1);
      chk(strap_pin_oe_o, 32'h1);
      // Test mode floats every pad and the strap pin
      test_hiz_i <= 1'b1;
      @(posedge clk_i);
      chk(pin_oe_o, 32'h0);
      chk(mux_bus_addr_oe_o, 32'h0);
      chk(strap_pin_oe_o, 32'h0);
      test_hiz_i <= 1'b0;
      @(posedge clk_i);
      bcyc(20'h00600, 1'b0, 1'b0);
      bcyc(20'h00700, 1'b1, 1'b0);
      wr(OFS_AUX_CTRL, 32'h0801);
      bcyc(20'h00E00, 1'b0, 1'b0);
      bcyc(20'h00600, 1'b1, 1'b0);
      bus_hold_i <= 1'b1;
      bcyc(20'h00E00, 1'b1, 1'b0);
      chk(strap_pin_oe_o, 32'h0);
      bus_hold_i <= 1'b0;
      wr(OFS_AUX_CTRL, 32'h0800);
      bcyc(20'h00E04, 1'b1, 1'b1);
      bus_hold_i <= 1'b1;
      bcyc(20'h00E00, 1'b1, 1'b1);
      bus_hold_i <= 1'b0;
      bcyc(20'h00E00, 1'b1, 1'b0);
      rst(1'b1);
      rdc(OFS_ENABLE, RST_ENABLE & ~STRAP_REVERT);
      chk(status_pins_normal_o, 32'h1);
      // Strap low: mux bus keeps its address even with the float bit set
      lower_upper_cycle_i <= 1'b1;
      wr(OFS_AUX_CTRL, 32'h0002);
      chk(mux_bus_addr_oe_o, 32'h1);
      tally_and_finish();
   end
endmodule
